//--- include/laser_st_pkg.sv
package laser_check_pkg;
    // clock
    localparam int unsigned CLK_HZ = 50_000_000;
    // analog comparator thresholds, in millivolts, fed to the analog front end
    localparam logic [11:0] LOW_THRESH_MV = 12'h190;   // 0.4 V
    localparam logic [11:0] HIGH_THRESH_MV = 12'h4B0;  // 1.2 V
    localparam logic [7:0] TEST_CURRENT_MA = 8'h0A;    // 10 mA laser test current
    // analog settle time per check, in microseconds
    localparam int unsigned SETTLE_US = 100;
    localparam int unsigned SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000) < 1) ? 1
                                         : SETTLE_US * (CLK_HZ / 1_000_000);
    // inactivity intervals
    localparam int unsigned FIRST_IDLE_MS = 50;
    localparam int unsigned SECOND_IDLE_S = 8;
    localparam int unsigned SLEEP_S = 600;   // 10 minutes
    localparam longint unsigned FIRST_IDLE_CYC = longint'(FIRST_IDLE_MS) * CLK_HZ / 1000;
    localparam longint unsigned SECOND_IDLE_CYC = longint'(SECOND_IDLE_S) * CLK_HZ;
    localparam longint unsigned SLEEP_CYC = longint'(SLEEP_S) * CLK_HZ;
    // battery conversion width
    localparam int unsigned VBAT_W = 8;
    localparam logic [7:0] VBAT_RESET = 8'h00;
    // values after reset and failed-check codes
    localparam logic [15:0] SETTLE_RESET = 16'h0000;
    localparam logic [39:0] QUIET_RESET = 40'h00_0000_0000;
    localparam logic [2:0] FAIL_NONE = 3'h0;
    localparam logic [2:0] FAIL_RBIN = 3'h1;
    localparam logic [2:0] FAIL_VDD = 3'h2;
    localparam logic [2:0] FAIL_GND = 3'h4;

    typedef enum logic [5:0] {
        PH_RBIN = 6'b000001,
        PH_SHORT_VDD = 6'b000010,
        PH_SHORT_GND = 6'b000100,
        PH_RUN = 6'b001000,
        PH_FAULT = 6'b010000,
        PH_START = 6'b100000
    } check_phase_e;

    typedef enum logic [3:0] {
        PWR_RUN = 4'b0001,
        PWR_FIRST_IDLE = 4'b0010,
        PWR_SECOND_IDLE = 4'b0100,
        PWR_SLEEP = 4'b1000
    } power_state_e;
endpackage : laser_check_pkg

//--- design/laser_fault_self_test.sv
`timescale 1ns/10ps
module laser_fault_self_test
    import laser_check_pkg::*;
#(
    parameter longint unsigned FIRST_IDLE_CYCLES = FIRST_IDLE_CYC,
    parameter longint unsigned SECOND_IDLE_CYCLES = SECOND_IDLE_CYC,
    parameter longint unsigned SLEEP_CYCLES = SLEEP_CYC,
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    // analog front end: comparator results for the currently selected check
    input wire logic rbin_above_low,
    input wire logic laser_above_low,
    input wire logic laser_above_high,
    // motion engine and adc
    input wire logic motion_detected,
    input wire logic laser_strobe,
    input wire logic adc_valid,
    input wire logic [VBAT_W-1:0] adc_data,
    // analog control
    output logic rbin_measure_en,
    output logic laser_test_current_en,
    output logic laser_pullup_en,
    output logic laser_drive_on,
    output logic laser_supply_switch_n,
    // status
    output logic self_test_done,
    output logic laser_fault,
    output logic [2:0] fault_check,
    output logic motion,
    output logic [3:0] power_state,
    output logic [VBAT_W-1:0] vbat_value
);
    // the quiet counter is 40 bits wide and the settle counter 16 bits wide
    localparam longint unsigned QUIET_MAX = 64'h0000_00FF_FFFF_FFFF;
    localparam int unsigned SETTLE_MAX = 65535;

    if (FIRST_IDLE_CYCLES == 0) begin : g_bad_first_idle
        $error("first idle interval must be nonzero");
    end
    if (SECOND_IDLE_CYCLES <= FIRST_IDLE_CYCLES) begin : g_bad_second_idle
        $error("second idle interval must exceed the first");
    end
    if (SLEEP_CYCLES <= SECOND_IDLE_CYCLES) begin : g_bad_sleep
        $error("sleep interval must exceed the second idle interval");
    end
    if (SLEEP_CYCLES > QUIET_MAX) begin : g_bad_quiet_width
        $error("sleep interval does not fit the quiet counter");
    end
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > SETTLE_MAX) begin : g_bad_settle
        $error("settle count out of range");
    end

    typedef struct packed {
        check_phase_e phase;
        logic [15:0] settle;
        logic [2:0] fail;
        power_state_e pwr;
        logic [39:0] quiet;
        logic mot;
        logic [VBAT_W-1:0] vbat;
    } state_s;

    state_s s_reg;
    state_s s_next;

    // true on the last edge of a check; only then is the comparator trusted to have settled
    function automatic logic settle_last(input logic [15:0] count);
        return 32'(count) == SETTLE_CYCLES - 1;
    endfunction : settle_last

    // cannot wrap: the elaboration check keeps the settle count inside 16 bits
    function automatic logic [15:0] settle_step(input logic [15:0] count);
        return count + 16'h0001;
    endfunction : settle_step

    // deepest power state that the quiet count has reached
    function automatic power_state_e power_level(input logic [39:0] quiet);
        power_state_e lvl;
        lvl = PWR_RUN;
        if (64'(quiet) >= SLEEP_CYCLES) begin
            lvl = PWR_SLEEP;
        end else if (64'(quiet) >= SECOND_IDLE_CYCLES) begin
            lvl = PWR_SECOND_IDLE;
        end else if (64'(quiet) >= FIRST_IDLE_CYCLES) begin
            lvl = PWR_FIRST_IDLE;
        end
        return lvl;
    endfunction : power_level

    always_comb begin
        s_next = s_reg;

        // three checks in a fixed order, each held for SETTLE_CYCLES edges
        case (s_reg.phase)
            PH_START: begin
                s_next.phase = PH_RBIN;
                s_next.settle = SETTLE_RESET;
            end
            PH_RBIN: begin
                s_next.settle = settle_step(s_reg.settle);
                if (settle_last(s_reg.settle)) begin
                    s_next.settle = SETTLE_RESET;
                    if (!rbin_above_low) begin
                        s_next.fail = FAIL_RBIN;
                        s_next.phase = PH_FAULT;
                    end else begin
                        s_next.phase = PH_SHORT_VDD;
                    end
                end
            end
            PH_SHORT_VDD: begin
                s_next.settle = settle_step(s_reg.settle);
                if (settle_last(s_reg.settle)) begin
                    s_next.settle = SETTLE_RESET;
                    if (laser_above_high) begin
                        s_next.fail = FAIL_VDD;
                        s_next.phase = PH_FAULT;
                    end else begin
                        s_next.phase = PH_SHORT_GND;
                    end
                end
            end
            PH_SHORT_GND: begin
                s_next.settle = settle_step(s_reg.settle);
                if (settle_last(s_reg.settle)) begin
                    s_next.settle = SETTLE_RESET;
                    if (!laser_above_low) begin
                        s_next.fail = FAIL_GND;
                        s_next.phase = PH_FAULT;
                    end else begin
                        s_next.phase = PH_RUN;
                    end
                end
            end
            PH_RUN: begin
                s_next.phase = PH_RUN;
            end
            PH_FAULT: begin
                // only rst leaves this state, so a damaged path is never retried
                s_next.phase = PH_FAULT;
            end
            default: begin
                // an illegal code counts as a fault, so the laser stays off
                s_next.phase = PH_FAULT;
            end
        endcase

        s_next.mot = motion_detected;

        // inactivity timer only counts once normal operation has begun
        if (motion_detected || s_reg.phase != PH_RUN) begin
            s_next.quiet = QUIET_RESET;
            s_next.pwr = PWR_RUN;
        end else begin
            // saturate at the sleep count so the counter never wraps back to run
            if (64'(s_reg.quiet) < SLEEP_CYCLES) begin
                s_next.quiet = s_reg.quiet + 40'h00_0000_0001;
            end
            s_next.pwr = power_level(s_next.quiet);
        end

        // the last conversion is held until the next valid pulse
        if (adc_valid) begin
            s_next.vbat = adc_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg.phase <= PH_START;
            s_reg.settle <= SETTLE_RESET;
            s_reg.fail <= FAIL_NONE;
            s_reg.pwr <= PWR_RUN;
            s_reg.quiet <= QUIET_RESET;
            s_reg.mot <= 1'b0;
            s_reg.vbat <= VBAT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // analog switches follow the state register, so they never glitch between checks
    assign rbin_measure_en = (s_reg.phase == PH_RBIN);
    assign laser_test_current_en = (s_reg.phase == PH_SHORT_VDD);
    assign laser_pullup_en = (s_reg.phase == PH_SHORT_GND);

    // laser strobes only after a clean pass; off in fault and during checks
    assign laser_drive_on = (s_reg.phase == PH_RUN) && laser_strobe;

    // switch stays open until the checks pass, so an unchecked diode never sees supply
    assign laser_supply_switch_n = (s_reg.phase != PH_RUN);

    assign self_test_done = (s_reg.phase == PH_RUN) || (s_reg.phase == PH_FAULT);
    assign laser_fault = (s_reg.phase == PH_FAULT);
    assign fault_check = s_reg.fail;
    assign motion = s_reg.mot;
    assign power_state = s_reg.pwr;
    assign vbat_value = s_reg.vbat;
endmodule : laser_fault_self_test

//--- testbench/self_test_props.sv
`timescale 1ns/10ps
module self_test_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rbin_above_low,
    input wire logic laser_above_low,
    input wire logic laser_above_high,
    input wire logic motion_detected,
    input wire logic laser_drive_on,
    input wire logic laser_supply_switch_n,
    input wire logic laser_fault,
    input wire logic motion,
    input wire logic [2:0] fault_check,
    input wire logic [3:0] power_state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_fault_set(c); $rose(laser_fault) && fault_check == c; endsequence
    sequence s_run_entry; $fell(laser_supply_switch_n); endsequence
    a_fault_off: assert property (laser_fault |-> laser_supply_switch_n && !laser_drive_on)
        else $error("laser on");
    a_fault_kept: assert property (laser_fault |=> laser_fault) else $error("lost");
    a_rbin_fault: assert property (s_fault_set(3'h1) |-> !$past(rbin_above_low))
        else $error("rbin");
    a_vdd_fault: assert property (s_fault_set(3'h2) |-> $past(laser_above_high))
        else $error("vdd");
    a_gnd_fault: assert property (s_fault_set(3'h4) |-> !$past(laser_above_low))
        else $error("gnd");
    a_run_entry: assert property (s_run_entry |-> $past(laser_above_low) && !laser_fault)
        else $error("run");
    a_motion_echo: assert property (!$past(rst) |-> motion == $past(motion_detected))
        else $error("motion");
    a_sleep_order: assert property ($rose(power_state[3]) |-> $past(power_state[2]))
        else $error("sleep");
endmodule : self_test_props
bind laser_fault_self_test self_test_props u_props (.*);

//--- testbench/laser_diode_model.sv
`timescale 1ns/10ps
module laser_diode_model (
    input wire logic [2:0] shorts,
    input wire logic laser_supply_switch_n,
    output logic rbin_above_low,
    output logic laser_above_high,
    output logic laser_above_low,
    output logic lit
);
    // a set bit shorts one pin: rbin low, laser high, laser low
    assign rbin_above_low = !shorts[0];
    assign laser_above_high = shorts[1];
    assign laser_above_low = !shorts[2];
    assign lit = !laser_supply_switch_n;
endmodule : laser_diode_model

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb;
    logic core_clk = 0, rst = 1, motion_detected = 0, laser_strobe = 1, adc_valid = 1;
    logic rbin_above_low, laser_above_low, laser_above_high, laser_fault, motion, lit;
    logic rbin_measure_en, laser_test_current_en, laser_pullup_en, laser_drive_on;
    logic laser_supply_switch_n, self_test_done;
    logic [2:0] shorts = 3'h0, fault_check;
    logic [3:0] power_state;
    logic [7:0] adc_data = 8'hA5, vbat_value;
    int errors = 0, num_checks = 0;
    initial forever #10 core_clk = ~core_clk;
    laser_fault_self_test #(.FIRST_IDLE_CYCLES(10), .SECOND_IDLE_CYCLES(20), .SLEEP_CYCLES(30),
        .SETTLE_CYCLES(2)) uut (.*);
    laser_diode_model partner (.*);
    task automatic check(string w, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) errors++;
        if (seen !== exp) $display("Error %s expected %h seen %h", w, exp, seen);
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic test_sequence();
        @(negedge core_clk);
        check("rbin_en", rbin_measure_en, 8'h01);
        check("switch", laser_supply_switch_n, 8'h01);
        check("done", self_test_done, 8'h00);
        repeat (2) @(negedge core_clk);
        check("rbin_en", rbin_measure_en, 8'h00);
        check("current_en", laser_test_current_en, 8'h01);
        repeat (2) @(negedge core_clk);
        check("current_en", laser_test_current_en, 8'h00);
        check("pullup_en", laser_pullup_en, 8'h01);
        check("drive", laser_drive_on, 8'h00);
        repeat (2) @(negedge core_clk);
        check("pullup_en", laser_pullup_en, 8'h00);
        check("done", self_test_done, 8'h01);
        check("fault", laser_fault, 8'h00);
        $display("sequence test done");
    endtask : test_sequence
    task automatic test_run();
        check("drive", laser_drive_on, 8'h01);
        check("lit", lit, 8'h01);
        check("vbat", vbat_value, 8'hA5);
        // steps of 12 from a quiet count of 2 reach 14 and 26, between the 10, 20 and 30 cycle thresholds, then saturate at 30
        for (int k = 0; k < 3; k++) begin
            repeat (12) @(negedge core_clk);
            check("idle", power_state, 8'h02 << k);
        end
        motion_detected = 1;
        @(negedge core_clk);
        check("motion", motion, 8'h01);
        check("wake", power_state, 8'h01);
        laser_strobe = 0;
        @(negedge core_clk);
        check("strobe", laser_drive_on, 8'h00);
        laser_strobe = 1;
        adc_valid = 0;
        adc_data = 8'h3C;
        @(negedge core_clk);
        check("vbat", vbat_value, 8'hA5);
        adc_valid = 1;
        @(negedge core_clk);
        check("vbat", vbat_value, 8'h3C);
        $display("run test done");
    endtask : test_run
    task automatic test_faults();
        for (int i = 0; i < 3; i++) begin
            shorts = 3'h1 << i;
            rst = 1;
            @(negedge core_clk);
            rst = 0;
            repeat (9) @(negedge core_clk);
            check("code", fault_check, 8'h01 << i);
            check("lit", lit, 8'h00);
            check("fault", laser_fault, 8'h01);
            check("drive", laser_drive_on, 8'h00);
            check("done", self_test_done, 8'h01);
        end
        $display("fault test done");
    endtask : test_faults
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 0;
        test_sequence();
        repeat (2) @(negedge core_clk);
        test_run();
        test_faults();
        print_verdict();
    end
    initial begin
        #50000 errors++;
        print_verdict();
    end
endmodule : tb
